// ===== cf_pkg.sv
// Constants and helpers shared by the convergence framer.
package cf_pkg;
    localparam logic [7:0] SYNC_ONE   = 8'hF6;
    localparam logic [7:0] SYNC_TWO   = 8'h28;
    localparam logic [7:0] FILL       = 8'hCC;
    localparam logic [7:0] GROWTH     = 8'h00;
    localparam logic [7:0] USER_RST   = 8'h00;
    localparam logic [5:0] ROW_TOP    = 6'h24;
    localparam logic [5:0] COL_LAST   = 6'h38;
    localparam logic [5:0] COL_OVH    = 6'h03;
    localparam logic [5:0] ROW_USER   = 6'h05;
    localparam logic [5:0] ROW_PARITY = 6'h04;
    localparam logic [5:0] ROW_STATUS = 6'h03;
    localparam logic [5:0] ROW_MGMT2  = 6'h02;
    localparam logic [5:0] ROW_MGMT1  = 6'h01;
    localparam logic [5:0] ROW_STUFF  = 6'h00;
    localparam logic [5:0] ROW_GROW   = 6'h06;
    localparam logic [2:0] LSS_CONN   = 3'h0;
    localparam logic [2:0] LSS_DOWN   = 3'h3;
    localparam logic [2:0] LSS_UP     = 3'h6;
    localparam logic [3:0] FAR_END_ERROR_COUNT_NONE  = 4'hF;
    localparam logic [3:0] FAR_END_ERROR_COUNT_MAX   = 4'h8;
    localparam logic [3:0] AS_FRAMES  = 4'hA;
    localparam logic [6:0] TRL_MIN    = 7'h36;
    localparam logic [6:0] TRL_MAX    = 7'h3A;
    localparam logic [7:0] STUFF_CODE [5] =
        '{8'h3B, 8'h4F, 8'h75, 8'h9D, 8'hA7};
    localparam int FRAME_US    = 125;
    localparam int AS_SET_MS   = 2500;
    localparam int AS_CLR_MS   = 15000;
    localparam int AS_SET_FRM  = AS_SET_MS * 1000 / FRAME_US;
    localparam int AS_CLR_FRM  = AS_CLR_MS * 1000 / FRAME_US;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_USER   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_INFO   = 4'hC;
    localparam logic [4:0] CTRL_RST   = 5'h03;
    localparam logic [1:0] RESP_OK    = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;
    typedef enum logic [2:0] {
        RX_HUNT  = 3'b001,
        RX_LOCK  = 3'b010,
        RX_TRAIL = 3'b100
    } cf_rx_t;
    // Row identifier: number, reserved zero, odd parity bit.
    function automatic logic [7:0] row_code(input logic [5:0] r);
        return {r, 1'b0, ~^r};
    endfunction : row_code
    function automatic logic row_ok(input logic [7:0] d);
        return d[7:2] <= ROW_TOP && !d[1] && ^d;
    endfunction : row_ok
    function automatic logic [3:0] ones(input logic [7:0] d);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++) n = n + {3'h0, d[i]};
        return n;
    endfunction : ones
endpackage : cf_pkg

// ===== cf_framer.sv
// Convergence framer: transmit framing, receive checks, register slave.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
module cf_framer #(
    parameter int unsigned SET_FRAMES = cf_pkg::AS_SET_FRM,
    parameter int unsigned CLR_FRAMES = cf_pkg::AS_CLR_FRM
) (
    input  wire logic        i_clock,
    input  wire logic        i_srst,
    input  wire logic        i_frame_tick,
    input  wire logic        i_tx_take,
    output logic       [7:0] o_tx_data,
    output logic             o_tx_strobe,
    input  wire logic  [7:0] i_slot_data,
    output logic             o_slot_take,
    input  wire logic  [7:0] i_mgmt_one,
    input  wire logic  [7:0] i_mgmt_two,
    input  wire logic        i_loss_of_frame,
    input  wire logic        i_rx_valid,
    input  wire logic  [7:0] i_rx_data,
    output logic       [7:0] o_rx_slot_data,
    output logic             o_rx_slot_valid,
    output logic       [7:0] o_mgmt_one,
    output logic       [7:0] o_mgmt_two,
    output logic             o_mgmt_strobe,
    output logic             o_in_frame,
    output logic             o_far_alarm,
    input  wire logic  [3:0] i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic  [3:0] i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic       [1:0] o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic  [3:0] i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic      [31:0] o_rdata,
    output logic       [1:0] o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    logic  [4:0] ctrl_reg;
    logic  [7:0] user_reg;
    logic  [5:0] tx_row;
    logic  [5:0] tx_col;
    logic        tx_trail;
    logic  [6:0] trl_cnt;
    logic  [7:0] stuff_reg;
    logic  [7:0] tx_bip;
    logic  [7:0] tx_par;
    logic  [7:0] tx_oct;
    logic        tx_slot;
    logic [16:0] set_cnt;
    logic [16:0] clr_cnt;
    logic        tx_alarm;
    logic  [3:0] loc_err;
    cf_pkg::cf_rx_t rx_st;
    logic  [5:0] rx_row;
    logic  [5:0] rx_col;
    logic  [7:0] prev1;
    logic  [7:0] prev2;
    logic        one_bad;
    logic        id_bad;
    logic        rx_hit;
    logic        rx_body;
    logic        rx_ovh;
    logic  [7:0] rx_acc;
    logic  [7:0] rx_par;
    logic        par_ok;
    logic  [3:0] rx_far_end_error_count;
    logic  [2:0] rx_lss;
    logic  [3:0] al_cnt;
    logic  [7:0] rx_user;
    logic  [7:0] rx_stuff;
    logic  [6:0] trl_c;

    // Octet at the current position; slots are pulled only as sent.
    always_comb begin
        tx_oct = cf_pkg::FILL;
        tx_slot = 1'b0;
        if (!tx_trail) begin
            if (tx_col == 6'h00) begin
                tx_oct = cf_pkg::SYNC_ONE;
            end else if (tx_col == 6'h01) begin
                tx_oct = cf_pkg::SYNC_TWO;
            end else if (tx_col == 6'h02) begin
                tx_oct = cf_pkg::row_code(tx_row);
            end else if (tx_col == cf_pkg::COL_OVH) begin
                unique case (tx_row)
                    cf_pkg::ROW_USER:   tx_oct = user_reg;
                    cf_pkg::ROW_PARITY: tx_oct = tx_par;
                    cf_pkg::ROW_STATUS: begin
                        tx_oct = {ctrl_reg[1] ? loc_err : cf_pkg::FAR_END_ERROR_COUNT_NONE,
                                  ctrl_reg[0] & tx_alarm, ctrl_reg[4:2]};
                    end
                    cf_pkg::ROW_MGMT2:  tx_oct = i_mgmt_two;
                    cf_pkg::ROW_MGMT1:  tx_oct = i_mgmt_one;
                    cf_pkg::ROW_STUFF:  tx_oct = stuff_reg;
                    default:            tx_oct = cf_pkg::GROWTH;
                endcase
            end else begin
                tx_oct = i_slot_data;
                tx_slot = 1'b1;
            end
        end
    end

    // The line withholds i_tx_take over its own overhead, so the slot
    // source simply waits; no buffer is needed to absorb the gap.
    assign o_slot_take = tx_slot & i_tx_take;

    // Transmit position walks row by row, then the trailer.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tx_row <= cf_pkg::ROW_TOP;
            tx_col <= 6'h00;
            tx_trail <= 1'b0;
            trl_cnt <= 7'h00;
        end else if (i_frame_tick) begin
            tx_row <= cf_pkg::ROW_TOP;
            tx_col <= 6'h00;
            tx_trail <= 1'b0;
            trl_cnt <= 7'h00;
        end else if (i_tx_take) begin
            if (tx_trail) begin
                // The trailer runs until the next tick.
                if (trl_cnt != 7'h7F) trl_cnt <= trl_cnt + 7'h01;
            end else if (tx_col == cf_pkg::COL_LAST) begin
                tx_col <= 6'h00;
                if (tx_row == 6'h00) tx_trail <= 1'b1;
                else tx_row <= tx_row - 6'h01;
            end else begin
                tx_col <= tx_col + 6'h01;
            end
        end
    end

    // The stuff count names the trailer length of the last frame.
    always_comb begin
        trl_c = trl_cnt;
        if (trl_c < cf_pkg::TRL_MIN) trl_c = cf_pkg::TRL_MIN;
        if (trl_c > cf_pkg::TRL_MAX) trl_c = cf_pkg::TRL_MAX;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            stuff_reg <= cf_pkg::STUFF_CODE[2];
        end else if (i_frame_tick) begin
            stuff_reg <= cf_pkg::STUFF_CODE[3'(trl_c - cf_pkg::TRL_MIN)];
        end
    end

    // Parity over columns 3 to 56 is sent one frame later.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tx_bip <= 8'h00;
            tx_par <= 8'h00;
        end else if (i_frame_tick) begin
            tx_par <= tx_bip;
            tx_bip <= 8'h00;
        end else if (i_tx_take && !tx_trail && tx_col >= cf_pkg::COL_OVH) begin
            tx_bip <= tx_bip ^ tx_oct;
        end
    end

    // Octet register toward the line, MSB sent first.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_tx_data <= 8'h00;
            o_tx_strobe <= 1'b0;
        end else begin
            o_tx_strobe <= i_tx_take;
            if (i_tx_take) o_tx_data <= tx_oct;
        end
    end

    // Alarm timers count frames, so a long loss costs few flops.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            set_cnt <= 17'h00000;
            clr_cnt <= 17'h00000;
            tx_alarm <= 1'b0;
        end else if (i_frame_tick) begin
            if (i_loss_of_frame) begin
                clr_cnt <= 17'h00000;
                if (set_cnt >= 17'(SET_FRAMES - 1)) tx_alarm <= 1'b1;
                else set_cnt <= set_cnt + 17'h00001;
            end else begin
                set_cnt <= 17'h00000;
                if (!tx_alarm) clr_cnt <= 17'h00000;
                else if (clr_cnt >= 17'(CLR_FRAMES - 1)) tx_alarm <= 1'b0;
                else clr_cnt <= clr_cnt + 17'h00001;
            end
        end
    end

    // Receive delineation uses the sync octets; header check is not built.
    assign rx_hit = prev2 == cf_pkg::SYNC_ONE && prev1 == cf_pkg::SYNC_TWO
                    && cf_pkg::row_ok(i_rx_data);
    assign rx_body = rx_st == cf_pkg::RX_LOCK && i_rx_valid
                     && rx_col >= cf_pkg::COL_OVH;
    assign rx_ovh = rx_body && rx_col == cf_pkg::COL_OVH;
    assign o_in_frame = rx_st != cf_pkg::RX_HUNT;

    // Lost after both sync octets bad or two bad row identifiers.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rx_st <= cf_pkg::RX_HUNT;
            rx_row <= 6'h00;
            rx_col <= 6'h00;
            prev1 <= 8'h00;
            prev2 <= 8'h00;
            one_bad <= 1'b0;
            id_bad <= 1'b0;
        end else if (i_rx_valid) begin
            prev1 <= i_rx_data;
            prev2 <= prev1;
            unique case (rx_st)
                cf_pkg::RX_HUNT, cf_pkg::RX_TRAIL: begin
                    if (rx_hit && (rx_st == cf_pkg::RX_HUNT
                        || i_rx_data[7:2] == cf_pkg::ROW_TOP)) begin
                        rx_st <= cf_pkg::RX_LOCK;
                        rx_row <= i_rx_data[7:2];
                        rx_col <= cf_pkg::COL_OVH;
                        id_bad <= 1'b0;
                    end
                end
                cf_pkg::RX_LOCK: begin
                    if (rx_col == cf_pkg::COL_LAST) begin
                        rx_col <= 6'h00;
                        if (rx_row == 6'h00) rx_st <= cf_pkg::RX_TRAIL;
                        else rx_row <= rx_row - 6'h01;
                    end else begin
                        rx_col <= rx_col + 6'h01;
                    end
                    if (rx_col == 6'h00) one_bad <= i_rx_data != cf_pkg::SYNC_ONE;
                    if (rx_col == 6'h01 && one_bad
                        && i_rx_data != cf_pkg::SYNC_TWO) rx_st <= cf_pkg::RX_HUNT;
                    if (rx_col == 6'h02) begin
                        if (!cf_pkg::row_ok(i_rx_data)
                            || i_rx_data[7:2] != rx_row) begin
                            id_bad <= 1'b1;
                            if (id_bad) rx_st <= cf_pkg::RX_HUNT;
                        end else begin
                            id_bad <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // Receive parity: accumulate, then compare at the parity row.
    always_ff @(posedge i_clock) begin
        if (i_srst || rx_st == cf_pkg::RX_HUNT) begin
            rx_acc <= 8'h00;
            rx_par <= 8'h00;
            par_ok <= 1'b0;
        end else if (rx_body) begin
            if (rx_col == cf_pkg::COL_LAST && rx_row == 6'h00) begin
                rx_par <= rx_acc ^ i_rx_data;
                rx_acc <= 8'h00;
                par_ok <= 1'b1;
            end else begin
                rx_acc <= rx_acc ^ i_rx_data;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            loc_err <= 4'h0;
        end else if (rx_ovh && rx_row == cf_pkg::ROW_PARITY && par_ok) begin
            loc_err <= cf_pkg::ones(i_rx_data ^ rx_par);
        end
    end

    // Status octet: error count, alarm filter and link status.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rx_far_end_error_count <= 4'h0;
            rx_lss <= cf_pkg::LSS_DOWN;
            al_cnt <= 4'h0;
            o_far_alarm <= 1'b0;
        end else if (rx_ovh && rx_row == cf_pkg::ROW_STATUS) begin
            if (i_rx_data[7:4] > cf_pkg::FAR_END_ERROR_COUNT_MAX
                && i_rx_data[7:4] != cf_pkg::FAR_END_ERROR_COUNT_NONE) begin
                rx_far_end_error_count <= 4'h0;
            end else begin
                rx_far_end_error_count <= i_rx_data[7:4];
            end
            if (i_rx_data[2:0] == cf_pkg::LSS_CONN
                || i_rx_data[2:0] == cf_pkg::LSS_DOWN
                || i_rx_data[2:0] == cf_pkg::LSS_UP) begin
                rx_lss <= i_rx_data[2:0];
            end
            if (i_rx_data[3] == o_far_alarm) begin
                al_cnt <= 4'h0;
            end else if (al_cnt == cf_pkg::AS_FRAMES - 4'h1) begin
                al_cnt <= 4'h0;
                o_far_alarm <= i_rx_data[3];
            end else begin
                al_cnt <= al_cnt + 4'h1;
            end
        end
    end

    // Remaining overhead is ended here; management is only relayed.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rx_user <= 8'h00;
            rx_stuff <= 8'h00;
            o_mgmt_one <= 8'h00;
            o_mgmt_two <= 8'h00;
            o_mgmt_strobe <= 1'b0;
            o_rx_slot_data <= 8'h00;
            o_rx_slot_valid <= 1'b0;
        end else begin
            o_mgmt_strobe <= rx_ovh && rx_row == cf_pkg::ROW_MGMT1;
            o_rx_slot_valid <= rx_body && rx_col > cf_pkg::COL_OVH;
            if (rx_body) o_rx_slot_data <= i_rx_data;
            if (rx_ovh) begin
                unique case (rx_row)
                    cf_pkg::ROW_USER:  rx_user <= i_rx_data;
                    cf_pkg::ROW_MGMT2: o_mgmt_two <= i_rx_data;
                    cf_pkg::ROW_MGMT1: o_mgmt_one <= i_rx_data;
                    cf_pkg::ROW_STUFF: rx_stuff <= i_rx_data;
                    default: ;
                endcase
            end
        end
    end

    // Write side: address and data latch in any order, then answer.
    logic        aw_hold;
    logic        w_hold;
    logic  [3:0] aw_q;
    logic [31:0] w_q;
    logic  [3:0] s_q;
    assign o_awready = !aw_hold && !o_bvalid;
    assign o_wready = !w_hold && !o_bvalid;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= 4'h0;
            w_q <= 32'h00000000;
            s_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= cf_pkg::RESP_OK;
            ctrl_reg <= cf_pkg::CTRL_RST;
            user_reg <= cf_pkg::USER_RST;
        end else begin
            if (o_awready && i_awvalid) begin
                aw_hold <= 1'b1;
                aw_q <= i_awaddr;
            end
            if (o_wready && i_wvalid) begin
                w_hold <= 1'b1;
                w_q <= i_wdata;
                s_q <= i_wstrb;
            end
            if (o_bvalid && i_bready) o_bvalid <= 1'b0;
            if (aw_hold && w_hold) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= cf_pkg::RESP_OK;
                if (aw_q == cf_pkg::REG_CTRL) begin
                    if (s_q[0]) ctrl_reg <= w_q[4:0];
                end else if (aw_q == cf_pkg::REG_USER) begin
                    if (s_q[0]) user_reg <= w_q[7:0];
                end else if (aw_q != cf_pkg::REG_STATUS
                             && aw_q != cf_pkg::REG_INFO) begin
                    o_bresp <= cf_pkg::RESP_ERR;
                end
            end
        end
    end

    // Read side: one read at a time, unmapped answers an error.
    assign o_arready = !o_rvalid;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h00000000;
            o_rresp <= cf_pkg::RESP_OK;
        end else if (o_rvalid) begin
            if (i_rready) o_rvalid <= 1'b0;
        end else if (i_arvalid) begin
            o_rvalid <= 1'b1;
            o_rresp <= cf_pkg::RESP_OK;
            unique case (i_araddr)
                cf_pkg::REG_CTRL:   o_rdata <= {27'h0, ctrl_reg};
                cf_pkg::REG_USER:   o_rdata <= {24'h0, user_reg};
                cf_pkg::REG_STATUS: o_rdata <= {20'h0, rx_far_end_error_count, 2'h0,
                    rx_lss, tx_alarm, o_far_alarm, o_in_frame};
                cf_pkg::REG_INFO:   o_rdata <= {8'h0, rx_stuff, rx_user,
                    4'h0, loc_err};
                default: begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= cf_pkg::RESP_ERR;
                end
            endcase
        end
    end

    a_sync_first: assert property (i_tx_take && !tx_trail && tx_col == 6'h00
        |=> o_tx_data == cf_pkg::SYNC_ONE) else $error("bad sync one");
    a_row_ident: assert property (i_tx_take && !tx_trail && tx_col == 6'h02
        |=> o_tx_data == cf_pkg::row_code($past(tx_row)) && ^o_tx_data)
        else $error("bad row identifier");
    a_growth_zero: assert property (i_tx_take && !tx_trail
        && tx_col == cf_pkg::COL_OVH && tx_row >= cf_pkg::ROW_GROW
        |=> o_tx_data == 8'h00) else $error("growth not zero");
    a_trailer_fill: assert property (i_tx_take && tx_trail
        |=> o_tx_data == cf_pkg::FILL) else $error("bad fill");
    a_row_length: assert property (tx_col == cf_pkg::COL_LAST && i_tx_take
        && !i_frame_tick && !tx_trail |=> tx_col == 6'h00)
        else $error("row not 57 octets");
    a_slot_take: assert property (o_slot_take |-> tx_col > cf_pkg::COL_OVH
        && !tx_trail) else $error("slot taken in overhead");
    a_lss_ignore: assert property (rx_ovh && rx_row == cf_pkg::ROW_STATUS
        && i_rx_data[1:0] == 2'h1 |=> $stable(rx_lss))
        else $error("undefined status taken");
    a_alarm_filter: assert property ($changed(o_far_alarm)
        |-> $past(al_cnt) == 4'h9) else $error("alarm unfiltered");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid
        && $stable(o_bresp)) else $error("write answer dropped");
endmodule : cf_framer

// ===== cf_peer.sv
// Line-side partner: takes framer octets with stalls and echoes them back.
module cf_peer (
    input  wire logic       i_clock,
    input  wire logic       i_srst,
    input  wire logic [7:0] i_line_data,
    input  wire logic       i_line_strobe,
    output logic            o_take,
    output logic            o_rx_valid,
    output logic      [7:0] o_rx_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Stalls stand for the line's own overhead octets; idle data is inverted.
    always_ff @(posedge i_clock) begin
        o_take     <= !i_srst && ($urandom_range(15) != 0);
        o_rx_valid <= i_line_strobe;
        o_rx_data  <= i_line_strobe ? i_line_data : ~o_rx_data;
    end
endmodule : cf_peer

// ===== tb.sv
// Self-checking bench for the framer in loopback through the line partner.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        i_clock = 1'b0, i_srst = 1'b1, i_frame_tick = 1'b0;
    logic        i_loss_of_frame = 1'b0, i_tx_take, i_rx_valid, o_tx_strobe;
    logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic        i_arvalid = 1'b0, i_rready = 1'b0, o_awready, o_wready;
    logic        o_bvalid, o_arready, o_rvalid, o_in_frame, o_far_alarm;
    logic [7:0]  i_slot_data = 8'h00, i_mgmt_one = 8'h00, i_mgmt_two = 8'h00;
    logic [7:0]  i_rx_data, o_tx_data, o_mgmt_one, user = 8'h00;
    logic [7:0]  o_mgmt_two, o_rx_slot_data, stuff, tx_sum = 8'h00;
    logic [7:0]  rx_sum = 8'h00;
    logic [2:0]  link_status_code = 3'h0;
    logic [1:0]  o_bresp, o_rresp;
    logic        o_slot_take, o_rx_slot_valid, slot;
    localparam int SET_FR = 3;
    int          trl, ticks, slot_tx = 0, slot_rx = 0;
    logic [7:0]  bip = 8'h00, prev_bip = 8'h00;
    logic [3:0]  i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [11:0] exp_q[$];
    logic [11:0] e;
    int          row, col, error_cnt = 0, num_checks = 0;

    cf_framer #(.SET_FRAMES(SET_FR), .CLR_FRAMES(5)) cf_framer_inst (
        .i_clock, .i_srst, .i_frame_tick, .i_tx_take, .o_tx_data,
        .o_tx_strobe, .i_slot_data, .o_slot_take, .i_mgmt_one, .i_mgmt_two,
        .i_loss_of_frame, .i_rx_valid, .i_rx_data, .o_rx_slot_data,
        .o_rx_slot_valid, .o_mgmt_one, .o_mgmt_two, .o_mgmt_strobe(),
        .o_in_frame, .o_far_alarm, .i_awaddr, .i_awvalid, .o_awready,
        .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
        .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
        .o_rvalid, .i_rready);

    cf_peer cf_peer_inst (.i_clock, .i_srst, .i_line_data(o_tx_data),
        .i_line_strobe(o_tx_strobe), .o_take(i_tx_take),
        .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data));

    always #2 i_clock = ~i_clock;

    task automatic chk(input string s, input logic [31:0] seen,
                       input logic [31:0] x);
        num_checks++;
        if (seen !== x) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", s, x, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // Bits: 11 parity octet, 10 frame start, 9 parity area, 8 not compared.
    function automatic logic [11:0] exp_oct(int r, int c);
        logic [5:0] n;
        n = r[5:0];
        if (r < 0)
            return 12'h0CC;
        case (c)
            0: return {1'b0, r == 36, 2'h0, 8'hF6};
            1: return 12'h028;
            2: return {4'h0, n, 1'b0, ~^n};
            3: return r > 5 ? 12'h200 : r == 5 ? {4'h2, user} :
                r == 4 ? 12'hA00 : r == 3 ? {8'h20, ticks >= SET_FR, link_status_code} :
                r == 2 ? {4'h2, i_mgmt_two} :
                r == 1 ? {4'h2, i_mgmt_one} : {4'h2, stuff};
            default: return {4'h2, i_slot_data};
        endcase
    endfunction : exp_oct

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        chk("bresp", {30'h0, o_bresp}, {30'h0, cf_pkg::RESP_OK});
        i_bready <= 1'b0;
        @(posedge i_clock);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] x);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clock);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        chk("rdata", o_rdata & m, x);
        chk("rresp", {30'h0, o_rresp}, {30'h0, cf_pkg::RESP_OK});
        i_rready <= 1'b0;
        @(posedge i_clock);
    endtask : rd

    // Slot octets change every cycle so a stale sample is caught.
    always @(posedge i_clock) i_slot_data <= 8'($urandom);

    // Notes the expected octet for every take, mirroring the row position.
    always @(posedge i_clock) begin
        if (i_tx_take === 1'b1 && !i_srst) begin
            exp_q.push_back(exp_oct(row, col));
            slot = row >= 0 && col > 3;
            chk("slot_take", {31'h0, o_slot_take}, {31'h0, slot});
            if (slot) begin
                slot_tx++;
                tx_sum = tx_sum ^ i_slot_data;
            end
            // The octet sent in the tick cycle is not part of the count.
            if (row < 0 && !i_frame_tick) trl++;
            col = col + 1;
            if (col == 57) begin
                col = 0;
                row = row - 1;
            end
        end
        if (i_srst) begin
            stuff = cf_pkg::STUFF_CODE[2];
            ticks = 0;
        end else if (i_frame_tick) begin
            stuff = cf_pkg::STUFF_CODE[trl < cf_pkg::TRL_MIN ? 0 :
                trl > cf_pkg::TRL_MAX ? 4 : trl - cf_pkg::TRL_MIN];
            ticks++;
        end
        if (i_srst || i_frame_tick) begin
            row = 36;
            col = 0;
            trl = 0;
        end
    end

    // Compares each strobed octet with the oldest note and keeps the BIP-8.
    always @(posedge i_clock) begin
        if (o_tx_strobe === 1'b1) begin
            e = exp_q.pop_front();
            if (e[10]) begin
                prev_bip = bip;
                bip = 8'h00;
            end
            if (e[11]) chk("parity", {24'h0, o_tx_data}, {24'h0, prev_bip});
            else if (!e[8]) chk("tx", {24'h0, o_tx_data}, {24'h0, e[7:0]});
            if (e[9]) bip = bip ^ o_tx_data;
        end
        // Looped-back slot octets are tallied against those sent.
        if (o_rx_slot_valid === 1'b1) begin
            slot_rx++;
            rx_sum = rx_sum ^ o_rx_slot_data;
        end
    end

    initial begin
        void'($urandom(32'h97AEB9F2));
        repeat (10) @(posedge i_clock);
        i_srst <= 1'b0;
        i_mgmt_one <= 8'($urandom);
        i_mgmt_two <= 8'($urandom);
        i_loss_of_frame <= 1'b1;
        rd(cf_pkg::REG_CTRL, 32'hFFFFFFFF, 32'h3);
        for (int f = 0; f < 18; f++) begin
            if (f == 1) begin
                user = 8'($urandom);
                wr(cf_pkg::REG_USER, {24'h0, user});
                rd(cf_pkg::REG_USER, 32'hFF, {24'h0, user});
                link_status_code = 3'h5;
                wr(cf_pkg::REG_CTRL, 32'h17);
                rd(cf_pkg::REG_CTRL, 32'h1F, 32'h17);
            end
            repeat (2399) @(posedge i_clock);
            i_frame_tick <= 1'b1;
            @(posedge i_clock);
            i_frame_tick <= 1'b0;
        end
        chk("in_frame", {31'h0, o_in_frame}, 32'h1);
        chk("far_alarm", {31'h0, o_far_alarm}, 32'h1);
        chk("mgmt_one", {24'h0, o_mgmt_one}, {24'h0, i_mgmt_one});
        chk("mgmt_two", {24'h0, o_mgmt_two}, {24'h0, i_mgmt_two});
        chk("slot_cnt", slot_rx, slot_tx);
        chk("slot_sum", {24'h0, rx_sum}, {24'h0, tx_sum});
        // Link code 000 arrived in the first frame; 101 later is ignored.
        rd(cf_pkg::REG_STATUS, 32'hF3F, 32'h7);
        rd(cf_pkg::REG_INFO, 32'hFF0F, {16'h0, user, 8'h00});
        end_sim;
    end

    // Cuts a hang short well after the planned run of eighteen frames.
    initial begin
        #300us;
        error_cnt++;
        end_sim;
    end
endmodule : tb
